/* sfrp_chk.sv */
// Port assertions for the serial flash host
`timescale 1ns/100ps
module sfrp_chk
	import sfrp_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic io0_out,
	input wire logic io0_oe,
	input wire logic io0_in,
	input wire logic io1_out,
	input wire logic io1_oe,
	input wire logic io1_in,
	input wire logic wp_n
);
	logic [15:0] rises_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	always_ff @(posedge clk) begin
		if (reset || cs_n) begin
			rises_q <= 16'h0000;
		end else if ($rose(sclk)) begin
			rises_q <= rises_q + 16'h0001;
		end
	end
	rdata_slot_a: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata outside slot");
	unmapped_zero_a: assert property (rd && addr > SFRP_REG_DIV |=> rdata == 32'h0) else $error("unmapped read");
	sclk_idle_a: assert property (cs_n |-> !sclk) else $error("sclk not idle low");
	line_release_a: assert property ($rose(cs_n) |=> !io0_oe && !io1_oe) else $error("lines held");
	opcode_drive_a: assert property ($rose(sclk) && !cs_n && rises_q < 16'h0008 |-> io0_oe && !io1_oe)
		else $error("opcode lines");
	half_period_a: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk) else $error("sclk half period");
	frame_start_a: assert property (wr && addr == SFRP_REG_CTRL && wdata[7] && cs_n |-> ##[1:3] !cs_n)
		else $error("no frame start");
	wp_drive_a: assert property (wr && addr == SFRP_REG_CTRL && cs_n |-> ##2 wp_n == !$past(wdata[4], 2))
		else $error("wp level");
endmodule

/* sfrp_clkdiv.sv */
// Link clock divider producing serial clock edge strobes
`timescale 1ns/100ps
module sfrp_clkdiv (
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [7:0] half_period,
	output logic sclk,
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic [7:0] cnt;
		logic sclk;
	} sfrp_div_s;
	sfrp_div_s q, d;
	logic tick;
	always_comb begin
		d = q;
		tick = 1'b0;
		if (!run) begin
			d.cnt = 8'h00;
			d.sclk = 1'b0;
		end else if (q.cnt >= half_period) begin
			d.cnt = 8'h00;
			d.sclk = ~q.sclk;
			tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 8'h01;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign sclk = q.sclk;
	assign rise = tick & ~q.sclk;
	assign fall = tick & q.sclk;
endmodule

/* sfrp_flash_model.sv */
// Behavioural flash device facing the host
`timescale 1ns/100ps
module sfrp_flash_model #(
	parameter int WTIME = 20000
) (
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic wp_n,
	input wire logic i0,
	input wire logic i1,
	output logic o0,
	output logic o1,
	output logic e0,
	output logic e1
);
	logic [7:0] sr = 8'h00;
	logic [7:0] op;
	logic [7:0] wd;
	logic [7:0] b;
	logic [23:0] a;
	int n = 0;
	int s;
	int k;
	initial begin
		{o0, o1, e0, e1} = 4'h0;
	end
	always @(negedge cs_n) begin
		n = 0;
	end
	always @(posedge sclk) begin
		if (!cs_n) begin
			n++;
			if (n <= 8) op = {op[6:0], i0};
			else if (op == 8'hBB && n <= 20) a = {a[21:0], i1, i0};
			else if (op != 8'hBB && n <= 32) a = {a[22:0], i0};
			wd = {wd[6:0], i0};
		end
	end
	always @(negedge sclk) begin
		if (!cs_n) begin
			s = (op == 8'h03) ? 32 : (op == 8'hBB) ? 24 : (op == 8'h05 || op == 8'h15) ? 8 : 40;
			if (n >= s && !(sr[0] && op != 8'h03 && op != 8'h05 && op != 8'h15)) begin
				k = (op == 8'h3B || op == 8'hBB) ? 2 * (n - s) : n - s;
				// Config reads zero: array end at top
				b = (op == 8'h05) ? sr : (op == 8'h15) ? 8'h00 : 8'(a + k / 8) ^ 8'h5A;
				o1 = b[7 - k % 8];
				o0 = b[(14 - k % 8) % 8];
				e1 = 1'b1;
				e0 = (op == 8'h3B || op == 8'hBB);
			end else begin
				{e0, e1} = 2'b00;
			end
		end
	end
	always @(posedge cs_n) begin
		{e0, e1} = 2'b00;
		if (op == 8'h06 && n == 8) sr[1] = 1'b1;
		// Lock mode
		if (op == 8'h01 && n == 16 && sr[1] && !(sr[7] && !wp_n && !sr[6])) begin
			sr[7:2] = wd[7:2];
			sr[0] = 1'b1;
		end
	end
	always @(posedge sr[0]) begin
		#(WTIME) sr[1:0] = 2'b00;
	end
endmodule

/* sfrp_host.sv */
// Serial flash host controller: register port to the flash link
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
module sfrp_host (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic cs_n,
	output logic sclk,
	output logic io0_out,
	output logic io0_oe,
	input wire logic io0_in,
	output logic io1_out,
	output logic io1_oe,
	input wire logic io1_in,
	output logic wp_n
);
	import sfrp_pkg::*;
	typedef struct packed {
		sfrp_state_e st;
		logic [2:0] cmd;
		logic dsel;
		logic wp;
		logic busy;
		logic done;
		logic refused;
		logic [23:0] faddr;
		logic [7:0] wbyte;
		logic [15:0] len;
		logic [15:0] left;
		logic [7:0] div;
		logic [7:0] sh;
		logic [23:0] ash;
		logic [4:0] bits;
		logic [7:0] rbyte;
		logic rvalid;
		logic dual;
		logic [31:0] rdata;
		logic [1:0] s0;
		logic [1:0] s1;
		logic cs_n;
		logic o0;
		logic o1;
		logic oe0;
		logic oe1;
	} sfrp_host_s;
	sfrp_host_s q, d;
	logic run, rise, fall;
	logic [7:0] op;
	logic [4:0] ndummy;
	logic [1:0] step;
	logic pin0, pin1;
	sfrp_clkdiv u_div (
		.clk(clk),
		.reset(reset),
		.run(run),
		.half_period(q.div),
		.sclk(sclk),
		.rise(rise),
		.fall(fall)
	);
	assign run = (q.st == SFRP_LATCH) || (q.st == SFRP_OPCODE) || (q.st == SFRP_ADDR)
		|| (q.st == SFRP_DUMMY) || (q.st == SFRP_DATA) || (q.st == SFRP_END);
	assign pin0 = q.s0[1];
	assign pin1 = q.s1[1];
	always_comb begin
		unique case (q.cmd)
			SFRP_CMD_READ: op = SFRP_OP_READ;
			SFRP_CMD_FAST: op = SFRP_OP_FAST_READ;
			SFRP_CMD_DUAL_OUT: op = SFRP_OP_DUAL_OUT;
			SFRP_CMD_DUAL_IO: op = SFRP_OP_DUAL_IO;
			SFRP_CMD_WRITE_STATUS: op = SFRP_OP_WRITE_STATUS;
			SFRP_CMD_READ_STATUS: op = SFRP_OP_READ_STATUS;
			SFRP_CMD_READ_CONFIG: op = SFRP_OP_READ_CONFIG;
			default: op = SFRP_OP_READ;
		endcase
		unique case (q.cmd)
			SFRP_CMD_FAST: ndummy = SFRP_DUMMY_FAST;
			SFRP_CMD_DUAL_OUT: ndummy = SFRP_DUMMY_DUAL_OUT;
			SFRP_CMD_DUAL_IO: ndummy = q.dsel ? SFRP_DUMMY_DUAL_IO_1 : SFRP_DUMMY_DUAL_IO_0;
			default: ndummy = 5'h00;
		endcase
	end
	assign step = q.dual ? SFRP_STEP_2 : SFRP_STEP_1;
	always_comb begin
		d = q;
		d.s0 = {q.s0[0], io0_in};
		d.s1 = {q.s1[0], io1_in};
		d.rvalid = 1'b0;
		d.rdata = 32'h0000_0000;
		if (rd) begin
			unique case (addr)
				SFRP_REG_CTRL: d.rdata = {24'h0, 3'h0, q.wp, q.dsel, q.cmd};
				SFRP_REG_ADDR: d.rdata = {8'h0, q.faddr};
				SFRP_REG_WDATA: d.rdata = {24'h0, q.wbyte};
				SFRP_REG_LEN: d.rdata = {16'h0, q.len};
				SFRP_REG_STATUS: d.rdata = {16'h0, q.left[7:0], 5'h0, q.refused, q.done, q.busy};
				SFRP_REG_RDATA: begin
					d.rdata = {24'h0, q.rbyte};
					d.done = 1'b0;
				end
				SFRP_REG_DIV: d.rdata = {24'h0, q.div};
				default: d.rdata = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			unique case (addr)
				SFRP_REG_CTRL: begin
					d.cmd = wdata[2:0];
					d.dsel = wdata[SFRP_CTRL_DUMMY];
					d.wp = wdata[SFRP_CTRL_WP];
					if (wdata[SFRP_CTRL_GO] && q.st == SFRP_IDLE) begin
						d.busy = 1'b1;
						d.done = 1'b0;
						d.refused = 1'b0;
						d.left = q.len;
						d.bits = SFRP_BITS_BYTE;
						d.oe1 = 1'b0;
						d.dual = 1'b0;
						if (wdata[2:0] == SFRP_CMD_WRITE_STATUS) begin
							// Own latch-set frame first; first bit stands before the first rise
							d.st = SFRP_LATCH;
							d.cs_n = 1'b0;
							d.oe0 = 1'b1;
							d.o0 = SFRP_OP_LATCH_SET[7];
							d.sh = {SFRP_OP_LATCH_SET[6:0], 1'b0};
						end else begin
							d.st = SFRP_GAP;
						end
					end
				end
				SFRP_REG_ADDR: d.faddr = wdata[23:0];
				SFRP_REG_WDATA: d.wbyte = wdata[7:0];
				SFRP_REG_LEN: d.len = wdata[15:0];
				SFRP_REG_DIV: d.div = wdata[7:0];
				default: ;
			endcase
		end
		unique case (q.st)
			SFRP_IDLE: ;
			SFRP_LATCH: begin
				if (fall) begin
					d.bits = q.bits - 5'h01;
					if (q.bits == 5'h01) begin
						d.st = SFRP_GAP;
						d.cs_n = 1'b1;
						d.oe0 = 1'b0;
					end else begin
						d.o0 = q.sh[7];
						d.sh = {q.sh[6:0], 1'b0};
					end
				end
			end
			SFRP_GAP: begin
				// Enable follows one cycle later so a raised select always sees lines released
				d.st = SFRP_OPCODE;
				d.cs_n = 1'b0;
				d.o0 = op[7];
				d.sh = {op[6:0], 1'b0};
				d.bits = SFRP_BITS_BYTE;
			end
			SFRP_OPCODE: begin
				d.oe0 = 1'b1;
				if (fall) begin
					d.o0 = q.sh[7];
					d.sh = {q.sh[6:0], 1'b0};
					d.bits = q.bits - 5'h01;
					if (q.bits == 5'h01) begin
						if (q.cmd == SFRP_CMD_WRITE_STATUS) begin
							d.o0 = q.wbyte[7];
							d.sh = {q.wbyte[6:0], 1'b0};
							d.bits = SFRP_BITS_BYTE;
							d.st = SFRP_DATA;
						end else if (q.cmd == SFRP_CMD_READ_STATUS || q.cmd == SFRP_CMD_READ_CONFIG) begin
							d.oe0 = 1'b0;
							d.bits = SFRP_BITS_BYTE;
							d.st = SFRP_DATA;
						end else if (q.cmd == SFRP_CMD_DUAL_IO) begin
							d.dual = 1'b1;
							d.oe1 = 1'b1;
							d.o1 = q.faddr[23];
							d.o0 = q.faddr[22];
							d.ash = {q.faddr[21:0], 2'b00};
							d.bits = SFRP_BITS_ADDR;
							d.st = SFRP_ADDR;
						end else begin
							d.o0 = q.faddr[23];
							d.ash = {q.faddr[22:0], 1'b0};
							d.bits = SFRP_BITS_ADDR;
							d.st = SFRP_ADDR;
						end
					end
				end
			end
			SFRP_ADDR: begin
				if (fall) begin
					if (q.dual) begin
						d.o1 = q.ash[23];
						d.o0 = q.ash[22];
						d.ash = {q.ash[21:0], 2'b00};
					end else begin
						d.o0 = q.ash[23];
						d.ash = {q.ash[22:0], 1'b0};
					end
					d.bits = q.bits - {3'h0, step};
					if (q.bits == {3'h0, step}) begin
						d.o0 = 1'b0;
						d.o1 = 1'b0;
						d.bits = ndummy;
						d.st = SFRP_DUMMY;
						if (ndummy == 5'h00) begin
							d.oe0 = 1'b0;
							d.oe1 = 1'b0;
							d.bits = SFRP_BITS_BYTE;
							d.st = SFRP_DATA;
						end
					end
				end
			end
			SFRP_DUMMY: begin
				if (fall) begin
					d.o0 = 1'b0;
					d.o1 = 1'b0;
					d.bits = q.bits - 5'h01;
					// Held low for the first two dummy clocks, then released
					if (q.bits < ndummy) begin
						d.oe0 = 1'b0;
						d.oe1 = 1'b0;
					end
					if (q.bits == 5'h01) begin
						d.oe0 = 1'b0;
						d.oe1 = 1'b0;
						d.dual = (q.cmd == SFRP_CMD_DUAL_OUT) || (q.cmd == SFRP_CMD_DUAL_IO);
						d.bits = SFRP_BITS_BYTE;
						d.st = SFRP_DATA;
					end
				end
			end
			SFRP_DATA: begin
				if (q.cmd == SFRP_CMD_WRITE_STATUS) begin
					if (fall) begin
						d.bits = q.bits - 5'h01;
						// Stop on whole byte so the device accepts it
						if (q.bits == 5'h01) begin
							d.st = SFRP_END;
						end else begin
							d.o0 = q.sh[7];
							d.sh = {q.sh[6:0], 1'b0};
						end
					end
				end else begin
					if (rise) begin
						d.rbyte = q.dual ? {q.rbyte[5:0], pin1, pin0} : {q.rbyte[6:0], pin1};
						d.bits = q.bits - {3'h0, step};
						if (q.bits == {3'h0, step}) begin
							d.bits = SFRP_BITS_BYTE;
							d.done = 1'b1;
							d.faddr = q.faddr + 24'h000001;
							d.left = q.left - 16'h0001;
							if (q.left <= 16'h0001) begin
								d.st = SFRP_END;
							end
						end
					end
				end
			end
			SFRP_END: begin
				// Close only with the clock low, so the last high phase is whole
				if (fall || !sclk) begin
					d.cs_n = 1'b1;
					d.oe0 = 1'b0;
					d.oe1 = 1'b0;
					d.dual = 1'b0;
					d.busy = 1'b0;
					d.done = 1'b1;
					d.st = SFRP_IDLE;
				end
			end
			default: d.st = SFRP_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
			q.st <= SFRP_IDLE;
			q.cs_n <= 1'b1;
			q.div <= SFRP_DIV_RESET;
			q.s0 <= 2'b00;
			q.s1 <= 2'b00;
		end else begin
			q <= d;
		end
	end
	assign rdata = q.rdata;
	assign cs_n = q.cs_n;
	assign io0_out = q.o0;
	assign io0_oe = q.oe0;
	assign io1_out = q.o1;
	assign io1_oe = q.oe1;
	assign wp_n = ~q.wp;
endmodule

/* sfrp_pkg.sv */
// Constants and types for the serial flash host controller
package sfrp_pkg;
	localparam logic [7:0] SFRP_OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] SFRP_OP_READ = 8'h03;
	localparam logic [7:0] SFRP_OP_READ_STATUS = 8'h05;
	localparam logic [7:0] SFRP_OP_LATCH_SET = 8'h06;
	localparam logic [7:0] SFRP_OP_FAST_READ = 8'h0B;
	localparam logic [7:0] SFRP_OP_READ_CONFIG = 8'h15;
	localparam logic [7:0] SFRP_OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] SFRP_OP_DUAL_IO = 8'hBB;
	// Status register bits
	localparam int SFRP_SR_BUSY = 0;
	localparam int SFRP_SR_LATCH = 1;
	localparam int SFRP_SR_QUAD = 6;
	localparam int SFRP_SR_LOCK = 7;
	// Configuration register bits
	localparam int SFRP_CR_DRIVE = 0;
	localparam int SFRP_CR_ARRAY_END = 3;
	localparam int SFRP_CR_DUMMY = 6;
	// Dummy clocks
	localparam logic [4:0] SFRP_DUMMY_FAST = 5'h08;
	localparam logic [4:0] SFRP_DUMMY_DUAL_OUT = 5'h08;
	localparam logic [4:0] SFRP_DUMMY_DUAL_IO_0 = 5'h04;
	localparam logic [4:0] SFRP_DUMMY_DUAL_IO_1 = 5'h08;
	localparam logic [4:0] SFRP_DUMMY_QUAD_IO_0 = 5'h06;
	localparam logic [4:0] SFRP_DUMMY_QUAD_IO_1 = 5'h0A;
	// Host register map
	localparam logic [3:0] SFRP_REG_CTRL = 4'h0;
	localparam logic [3:0] SFRP_REG_ADDR = 4'h1;
	localparam logic [3:0] SFRP_REG_WDATA = 4'h2;
	localparam logic [3:0] SFRP_REG_LEN = 4'h3;
	localparam logic [3:0] SFRP_REG_STATUS = 4'h4;
	localparam logic [3:0] SFRP_REG_RDATA = 4'h5;
	localparam logic [3:0] SFRP_REG_DIV = 4'h6;
	// Control register command codes, bits 2:0
	localparam logic [2:0] SFRP_CMD_READ = 3'h0;
	localparam logic [2:0] SFRP_CMD_FAST = 3'h1;
	localparam logic [2:0] SFRP_CMD_DUAL_OUT = 3'h2;
	localparam logic [2:0] SFRP_CMD_DUAL_IO = 3'h3;
	localparam logic [2:0] SFRP_CMD_WRITE_STATUS = 3'h4;
	localparam logic [2:0] SFRP_CMD_READ_STATUS = 3'h5;
	localparam logic [2:0] SFRP_CMD_READ_CONFIG = 3'h6;
	localparam int SFRP_CTRL_GO = 7;
	localparam int SFRP_CTRL_DUMMY = 3;
	localparam int SFRP_CTRL_WP = 4;
	localparam logic [7:0] SFRP_DIV_RESET = 8'h04;
	localparam logic [4:0] SFRP_BITS_BYTE = 5'h08;
	localparam logic [4:0] SFRP_BITS_ADDR = 5'h18;
	localparam logic [1:0] SFRP_STEP_1 = 2'h1;
	localparam logic [1:0] SFRP_STEP_2 = 2'h2;
	typedef enum logic [2:0] {
		SFRP_IDLE = 3'b000,
		SFRP_LATCH = 3'b001,
		SFRP_GAP = 3'b010,
		SFRP_OPCODE = 3'b011,
		SFRP_ADDR = 3'b100,
		SFRP_DUMMY = 3'b101,
		SFRP_DATA = 3'b110,
		SFRP_END = 3'b111
	} sfrp_state_e;
endpackage

/* test_serial_flash_read_and_protect.sv */
// Self-checking bench for the serial flash host
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; $display("unexpected at %0t: %h not %h", $time, a, e); end end
module test_serial_flash_read_and_protect;
	import sfrp_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic tg = 1'b0;
	logic [31:0] rdata;
	logic cs_n, sclk, io0_out, io0_oe, io1_out, io1_oe, wp_n, o0, o1, e0, e1;
	wire io0 = io0_oe ? io0_out : e0 ? o0 : tg;
	wire io1 = io1_oe ? io1_out : e1 ? o1 : ~tg;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	sfrp_host uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.cs_n(cs_n), .sclk(sclk), .io0_out(io0_out), .io0_oe(io0_oe), .io0_in(io0), .io1_out(io1_out),
		.io1_oe(io1_oe), .io1_in(io1), .wp_n(wp_n));
	sfrp_flash_model #(.WTIME(20000)) flash (.cs_n(cs_n), .sclk(sclk), .wp_n(wp_n), .i0(io0), .i1(io1),
		.o0(o0), .o1(o1), .e0(e0), .e1(e1));
	initial forever #12.5 clk = ~clk;
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rreg(input logic [3:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	task automatic poll(input int b, input logic v);
		logic [31:0] s;
		for (int i = 0; i < 2000; i++) begin
			rreg(SFRP_REG_STATUS, s);
			if (s[b] === v) return;
		end
		`CHK(s[b], v)
	endtask
	task automatic frame(input logic [2:0] c, input logic w, input logic [23:0] a, input logic [7:0] n,
		input logic [7:0] e);
		logic [31:0] v;
		wreg(SFRP_REG_ADDR, {8'h00, a});
		wreg(SFRP_REG_LEN, {24'h0, n});
		wreg(SFRP_REG_CTRL, {24'h0, 1'b1, 2'b00, w, 1'b0, c});
		for (int i = 0; i < n; i++) begin
			poll(1, 1'b1);
			rreg(SFRP_REG_RDATA, v);
			`CHK(v[7:0], (c > 3'h3) ? e : 8'(a + i) ^ 8'h5A)
		end
		poll(0, 1'b0);
	endtask
	task automatic t_reset();
		logic [31:0] v;
		rreg(SFRP_REG_STATUS, v);
		`CHK(v, 32'h0)
		rreg(SFRP_REG_DIV, v);
		`CHK(v, {24'h0, SFRP_DIV_RESET})
		rreg(4'hF, v);
		`CHK(v, 32'h0)
	endtask
	task automatic t_reads();
		frame(SFRP_CMD_READ, 1'b0, 24'hFFFFFE, 8'h03, 8'h00);
		frame(SFRP_CMD_FAST, 1'b0, 24'h000100, 8'h02, 8'h00);
		frame(SFRP_CMD_DUAL_OUT, 1'b0, 24'h012345, 8'h02, 8'h00);
		frame(SFRP_CMD_DUAL_IO, 1'b0, 24'hABCDEF, 8'h02, 8'h00);
		frame(SFRP_CMD_READ_CONFIG, 1'b0, 24'h0, 8'h01, 8'h00);
	endtask
	task automatic t_protect();
		logic [16:0] tb [6] = '{{8'h3C, 1'b0, 8'h3C}, {8'h80, 1'b0, 8'h80}, {8'h00, 1'b1, 8'h82},
			{8'h00, 1'b0, 8'h00}, {8'hC0, 1'b0, 8'hC0}, {8'h00, 1'b1, 8'h00}};
		for (int i = 0; i < 6; i++) begin
			wreg(SFRP_REG_WDATA, {24'h0, tb[i][16:9]});
			frame(SFRP_CMD_WRITE_STATUS, tb[i][8], 24'h0, 8'h00, 8'h00);
			if (i == 0) frame(SFRP_CMD_READ_STATUS, 1'b0, 24'h0, 8'h01, 8'h3F);
			repeat (1000) @(posedge clk);
			frame(SFRP_CMD_READ_STATUS, 1'b0, 24'h0, 8'h01, tb[i][7:0]);
		end
	endtask
	task automatic results();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		t_reads();
		t_protect();
		results();
	end
	always @(posedge clk) begin
		tg <= ~tg;
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			error_cnt++;
			results();
		end
	end
endmodule
bind sfrp_host sfrp_chk chk (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .cs_n(cs_n), .sclk(sclk), .io0_out(io0_out), .io0_oe(io0_oe), .io0_in(io0_in),
	.io1_out(io1_out), .io1_oe(io1_oe), .io1_in(io1_in), .wp_n(wp_n));
